// ---- rtl/pse_pkg.sv ----
package pse_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [9:0] PSE_IDX_DIR = 10'h089;
	localparam logic [9:0] PSE_IDX_PINS = 10'h009;
	localparam logic [9:0] PSE_IDX_ANALOG = 10'h09F;
	localparam logic [9:0] PSE_IDX_PSP_DATA = 10'h008;
	localparam logic [9:0] PSE_IDX_IRQ_STATUS = 10'h00C;
	localparam logic [9:0] PSE_IDX_IRQ_CLEAR = 10'h00D;
	localparam logic [9:0] PSE_IDX_IRQ_ENABLE = 10'h00E;

	// Direction/slave-control register fields
	localparam int PSE_DIR_LSB = 0;
	localparam int PSE_DIR_MSB = 2;
	localparam int PSE_BIT_UNUSED = 3;
	localparam int PSE_BIT_MODE = 4;
	localparam int PSE_BIT_OVERRUN = 5;
	localparam int PSE_BIT_OUT_PENDING = 6;
	localparam int PSE_BIT_IN_FULL = 7;

	// Interrupt status/clear/enable layout
	localparam int PSE_IRQ_IN_WORD = 0;
	localparam int PSE_IRQ_OUT_TAKEN = 1;
	localparam int PSE_IRQ_OVERRUN = 2;

	// Reset values
	localparam logic [2:0] PSE_DIR_RESET = 3'h7;
	localparam logic [2:0] PSE_ANALOG_RESET = 3'h7;
	localparam logic [2:0] PSE_PINS_RESET = 3'h0;
	localparam logic [2:0] PSE_IRQ_RESET = 3'h0;
	localparam logic [7:0] PSE_BYTE_RESET = 8'h00;

	// AHB-Lite codes
	localparam logic [1:0] PSE_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] PSE_HTRANS_SEQ = 2'h3;

	// One bit per pin of the three-pin group
	typedef struct packed {
		logic select_strobe_pin;
		logic write_strobe_pin;
		logic read_strobe_pin;
	} pse_pin_trio_t;

	// Byte-wide slave data bus, pin view
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe;
	} pse_psp_drive_t;

endpackage

// ---- rtl/pse_port_e_slave.sv ----
`timescale 1ns/1ps
module pse_port_e_slave import pse_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Three-pin group
	input wire pse_pin_trio_t pin_group_e_level,
	output pse_pin_trio_t pin_group_e_drive,
	output pse_pin_trio_t pin_group_e_oe,
	// Byte-wide slave data bus
	input wire logic [7:0] psp_data_level,
	output pse_psp_drive_t psp_data_drv,
	// Interrupt
	output logic irq
);

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic [2:0] dir_r;
	logic mode_r;
	logic overrun_r;
	logic in_full_r;
	logic out_pending_r;
	logic [2:0] analog_r;
	logic [2:0] pins_r;
	logic [7:0] in_word_r;
	logic [7:0] out_word_r;
	logic [2:0] irq_status_r;
	logic [2:0] irq_enable_r;
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [2:0] pin_prev_r;
	logic [7:0] data_s1_r;
	logic [7:0] data_s2_r;
	logic [7:0] data_prev_r;
	logic wr_pend_r;
	logic [9:0] wr_idx_r;
	logic [31:0] hrdata_nxt;
	logic addr_ok;
	logic rd_go;
	logic [9:0] a_idx;
	logic ext_write_done;
	logic ext_read_done;
	logic ext_read_active;
	logic core_read_in;
	logic core_write_out;
	logic core_wr_dir;
	logic [2:0] irq_clear;
	logic [2:0] irq_event;
	logic [2:0] pin_digital;
	logic [7:0] dir_view;

	// Bus address phase
	assign addr_ok = hsel && hready && (htrans == PSE_HTRANS_NONSEQ || htrans == PSE_HTRANS_SEQ);
	assign rd_go = addr_ok && !hwrite;
	assign a_idx = haddr[11:2];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= 10'h000;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			wr_idx_r <= a_idx;
		end
	end

	// Zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Strobe and data pins pass two flip-flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_r <= 3'h7;
			pin_s2_r <= 3'h7;
			pin_prev_r <= 3'h7;
			data_s1_r <= PSE_BYTE_RESET;
			data_s2_r <= PSE_BYTE_RESET;
			data_prev_r <= PSE_BYTE_RESET;
		end else begin
			pin_s1_r <= pin_group_e_level;
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
			data_s1_r <= psp_data_level;
			data_s2_r <= data_s1_r;
			data_prev_r <= data_s2_r;
		end
	end

	// Strobe decode: bit 2 select, bit 1 write, bit 0 read, all active low
	assign ext_write_done = mode_r && !pin_prev_r[2] && !pin_prev_r[1] && pin_s2_r[1];
	assign ext_read_done = mode_r && !pin_prev_r[2] && !pin_prev_r[0] && pin_s2_r[0];
	assign ext_read_active = mode_r && !pin_s2_r[2] && !pin_s2_r[0];

	assign core_read_in = rd_go && a_idx == PSE_IDX_PSP_DATA;
	assign core_write_out = wr_pend_r && wr_idx_r == PSE_IDX_PSP_DATA;
	assign core_wr_dir = wr_pend_r && wr_idx_r == PSE_IDX_DIR;
	assign irq_clear = (wr_pend_r && wr_idx_r == PSE_IDX_IRQ_CLEAR) ? hwdata[2:0] : 3'h0;

	// Direction and mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_r <= PSE_DIR_RESET;
			mode_r <= 1'b0;
		end else if (core_wr_dir) begin
			dir_r <= hwdata[PSE_DIR_MSB:PSE_DIR_LSB];
			mode_r <= hwdata[PSE_BIT_MODE];
		end
	end

	// Overrun sticks; a new overrun beats a software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_r <= 1'b0;
		end else if (ext_write_done && in_full_r) begin
			overrun_r <= 1'b1;
		end else if (core_wr_dir && !hwdata[PSE_BIT_OVERRUN]) begin
			overrun_r <= 1'b0;
		end
	end

	// Input word; an overrunning write is dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_full_r <= 1'b0;
			in_word_r <= PSE_BYTE_RESET;
		end else if (ext_write_done && !in_full_r) begin
			in_full_r <= 1'b1;
			in_word_r <= data_prev_r;
		end else if (ext_write_done) begin
			in_full_r <= 1'b1;
		end else if (core_read_in) begin
			in_full_r <= 1'b0;
		end
	end

	// Output word; a new core write beats the external read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_pending_r <= 1'b0;
			out_word_r <= PSE_BYTE_RESET;
		end else if (core_write_out) begin
			out_pending_r <= 1'b1;
			out_word_r <= hwdata[7:0];
		end else if (ext_read_done) begin
			out_pending_r <= 1'b0;
		end
	end

	// Analog selection and pin output latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog_r <= PSE_ANALOG_RESET;
			pins_r <= PSE_PINS_RESET;
		end else begin
			if (wr_pend_r && wr_idx_r == PSE_IDX_ANALOG) begin
				analog_r <= hwdata[2:0];
			end
			if (wr_pend_r && wr_idx_r == PSE_IDX_PINS) begin
				pins_r <= hwdata[2:0];
			end
		end
	end

	// Pin drivers; direction applies whether analog or not
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_group_e_drive <= PSE_PINS_RESET;
			pin_group_e_oe <= 3'h0;
		end else begin
			pin_group_e_drive <= pins_r;
			pin_group_e_oe <= ~dir_r;
		end
	end

	// Data bus is driven while the external reader strobes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			psp_data_drv <= '0;
		end else begin
			psp_data_drv.data <= out_word_r;
			psp_data_drv.oe <= {8{ext_read_active}};
		end
	end

	// Interrupt events, one bit each
	always_comb begin
		irq_event = 3'h0;
		irq_event[PSE_IRQ_IN_WORD] = ext_write_done;
		irq_event[PSE_IRQ_OUT_TAKEN] = ext_read_done;
		irq_event[PSE_IRQ_OVERRUN] = ext_write_done && in_full_r;
	end

	// Sticky interrupt status; a new event beats a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_r <= PSE_IRQ_RESET;
			irq_enable_r <= PSE_IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_status_r <= (irq_status_r & ~irq_clear) | irq_event;
			if (wr_pend_r && wr_idx_r == PSE_IDX_IRQ_ENABLE) begin
				irq_enable_r <= hwdata[2:0];
			end
			irq <= |(irq_status_r & irq_enable_r);
		end
	end

	// Read data mux
	assign pin_digital = pin_s2_r & ~analog_r;

	// Status and control view
	always_comb begin
		dir_view = 8'h00;
		dir_view[PSE_DIR_MSB:PSE_DIR_LSB] = dir_r;
		dir_view[PSE_BIT_MODE] = mode_r;
		dir_view[PSE_BIT_OVERRUN] = overrun_r;
		dir_view[PSE_BIT_OUT_PENDING] = out_pending_r;
		dir_view[PSE_BIT_IN_FULL] = in_full_r;
	end

	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		case (a_idx)
			PSE_IDX_DIR: hrdata_nxt[7:0] = dir_view;
			PSE_IDX_PINS: hrdata_nxt[2:0] = pin_digital;
			PSE_IDX_ANALOG: hrdata_nxt[2:0] = analog_r;
			PSE_IDX_PSP_DATA: hrdata_nxt[7:0] = in_word_r;
			PSE_IDX_IRQ_STATUS: hrdata_nxt[2:0] = irq_status_r;
			PSE_IDX_IRQ_ENABLE: hrdata_nxt[2:0] = irq_enable_r;
			default: hrdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_go) begin
			hrdata <= hrdata_nxt;
		end
	end

	// Steps of strobe and bus traffic seen at the synchroniser output
	sequence s_ext_write_end;
		mode_r && !pin_prev_r[2] && !pin_prev_r[1] && pin_s2_r[1];
	endsequence

	sequence s_ext_read_end;
		mode_r && !pin_prev_r[2] && !pin_prev_r[0] && pin_s2_r[0];
	endsequence

	sequence s_dir_read;
		rd_go && a_idx == PSE_IDX_DIR;
	endsequence

	sequence s_pins_read;
		rd_go && a_idx == PSE_IDX_PINS;
	endsequence

	sequence s_soft_overrun_clear;
		core_wr_dir && !hwdata[PSE_BIT_OVERRUN];
	endsequence

	// Pin direction and mode
	a_dir_drives_oe: assert property (
		core_wr_dir |=> ##1 pin_group_e_oe == ~$past(hwdata[2:0], 2))
		else $error("pin enables do not follow direction write");
	a_mode_follows_write: assert property (
		core_wr_dir |=> mode_r == $past(hwdata[PSE_BIT_MODE]))
		else $error("mode bit does not follow direction write");
	a_analog_keeps_dir: assert property (##1 pin_group_e_oe == ~$past(dir_r))
		else $error("direction not applied to pin");
	a_gpio_no_strobe: assert property (!mode_r && !in_full_r |=> !in_full_r)
		else $error("input word taken outside slave mode");
	a_gpio_keeps_out: assert property (!mode_r && out_pending_r |=> out_pending_r)
		else $error("output word released outside slave mode");
	a_gpio_bus_quiet: assert property (!mode_r |=> psp_data_drv.oe == 8'h00)
		else $error("data bus driven outside slave mode");

	// Register read view
	a_analog_reads_zero: assert property (
		s_pins_read |=> (hrdata[2:0] & $past(analog_r)) == 3'h0)
		else $error("analog pin read as one");
	a_pins_read_mask: assert property (
		s_pins_read |=> hrdata[2:0] == ($past(pin_s2_r) & ~$past(analog_r)))
		else $error("pin level read back wrong");
	a_dir_bit_map: assert property (
		s_dir_read |=> hrdata[2:0] == $past(dir_r) && hrdata[PSE_BIT_MODE] == $past(mode_r))
		else $error("direction bits read back wrong");
	a_unused_zero: assert property (s_dir_read |=> hrdata[PSE_BIT_UNUSED] == 1'b0)
		else $error("unimplemented bit reads one");
	a_upper_zero: assert property (rd_go |=> hrdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_flag_view: assert property (
		s_dir_read |=> hrdata[7:5] == {$past(in_full_r), $past(out_pending_r), $past(overrun_r)})
		else $error("status flags read back wrong");

	// Slave-port flags
	a_in_full_sets: assert property (
		s_ext_write_end ##0 !in_full_r |=> in_full_r && in_word_r == $past(data_prev_r))
		else $error("input word not captured");
	a_in_full_idle: assert property (!ext_write_done && !in_full_r |=> !in_full_r)
		else $error("input full set with no word");
	a_in_full_clears: assert property (core_read_in && !ext_write_done |=> !in_full_r)
		else $error("input full not cleared by core read");
	a_out_pend_sets: assert property (
		core_write_out |=> out_pending_r ##0 out_word_r == $past(hwdata[7:0]))
		else $error("output pending not set by core write");
	a_out_pend_clears: assert property (
		s_ext_read_end ##0 !core_write_out |=> !out_pending_r)
		else $error("output pending not cleared by external read");
	a_read_drives_bus: assert property (
		ext_read_active |=> psp_data_drv.oe == 8'hFF && psp_data_drv.data == $past(out_word_r))
		else $error("output word not driven to external reader");
	a_overrun_sticky: assert property (
		s_ext_write_end ##0 in_full_r |=> overrun_r ##1 (overrun_r || $past(core_wr_dir)))
		else $error("overrun lost");
	a_overrun_holds: assert property (overrun_r && !core_wr_dir |=> overrun_r)
		else $error("overrun dropped without software clear");
	a_overrun_clears: assert property (
		s_soft_overrun_clear ##0 !(ext_write_done && in_full_r) |=> !overrun_r)
		else $error("overrun not cleared by software");
	a_overrun_drops: assert property (
		s_ext_write_end ##0 in_full_r |=> in_word_r == $past(in_word_r))
		else $error("overrunning word replaced stored word");

endmodule

// ---- sim/pse_host_model.sv ----
`timescale 1ns/1ps
module pse_host_model import pse_pkg::*; (
	// Clock
	input wire logic hclk,
	// Slave data bus
	input wire logic [7:0] bus_level,
	output logic [7:0] bus_drive,
	// Strobes, active low
	output pse_pin_trio_t strobe_n
);
	initial begin
		strobe_n = 3'h7;
		bus_drive = 8'h00;
	end
	// Select and write low together, data held past the rise
	task automatic ext_write(input logic [7:0] b);
		@(posedge hclk);
		bus_drive <= b;
		strobe_n <= 3'h1;
		repeat (4) @(posedge hclk);
		strobe_n <= 3'h7;
		repeat (4) @(posedge hclk);
		bus_drive <= ~b;
		repeat (3) @(posedge hclk);
	endtask
	// Select and read low together, byte taken before the rise
	task automatic ext_read(output logic [7:0] b);
		@(posedge hclk);
		strobe_n <= 3'h2;
		repeat (6) @(posedge hclk);
		b = bus_level;
		strobe_n <= 3'h7;
		repeat (6) @(posedge hclk);
	endtask
endmodule

// ---- sim/test_port_e_parallel_slave_control.sv ----
`timescale 1ns/1ps
module test_port_e_parallel_slave_control import pse_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize, pins;
	logic [7:0] host_bus, psp_bus, b;
	pse_pin_trio_t pin_o, pin_oe, strobe_n;
	pse_psp_drive_t drv;
	int bad_count = 0;
	int num_checks = 0;
	// Wire levels seen by both parties
	assign pins = (pin_oe & pin_o) | (~pin_oe & strobe_n);
	assign psp_bus = (drv.oe & drv.data) | (~drv.oe & host_bus);
	pse_port_e_slave uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pin_group_e_level(pins), .pin_group_e_drive(pin_o), .pin_group_e_oe(pin_oe),
		.psp_data_level(psp_bus), .psp_data_drv(drv), .irq(irq));
	pse_host_model host (.hclk(hclk), .bus_level(psp_bus), .bus_drive(host_bus),
		.strobe_n(strobe_n));
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h00000, idx, 2'h0};
		hwrite <= w;
		htrans <= PSE_HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h00000000);
		check(rv, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		tally_and_finish;
	end
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(PSE_IDX_DIR, 32'h00000007);
		rchk(PSE_IDX_ANALOG, 32'h00000007);
		// General purpose pins: only the write pin drives
		bus(1'b1, PSE_IDX_ANALOG, 32'h00000000);
		bus(1'b1, PSE_IDX_DIR, 32'h00000005);
		bus(1'b1, PSE_IDX_PINS, 32'h00000002);
		rchk(PSE_IDX_DIR, 32'h00000005);
		check(pin_oe, 3'h2);
		check(pin_o, 3'h2);
		rchk(PSE_IDX_PINS, 32'h00000007);
		bus(1'b1, PSE_IDX_ANALOG, 32'h00000007);
		rchk(PSE_IDX_PINS, 32'h00000000);
		check(pin_oe, 3'h2);
		// Slave mode; writing bits 3 and 5 must leave them clear
		bus(1'b1, PSE_IDX_ANALOG, 32'h00000000);
		bus(1'b1, PSE_IDX_DIR, 32'h000000FF);
		bus(1'b1, PSE_IDX_IRQ_ENABLE, 32'h00000007);
		rchk(PSE_IDX_DIR, 32'h00000017);
		host.ext_write(8'hA5);
		rchk(PSE_IDX_DIR, 32'h00000097);
		check(irq, 1'b1);
		host.ext_write(8'h3C);
		rchk(PSE_IDX_DIR, 32'h000000B7);
		rchk(PSE_IDX_PSP_DATA, 32'h000000A5);
		rchk(PSE_IDX_DIR, 32'h00000037);
		bus(1'b1, PSE_IDX_DIR, 32'h00000017);
		rchk(PSE_IDX_DIR, 32'h00000017);
		rchk(PSE_IDX_IRQ_STATUS, 32'h00000005);
		bus(1'b1, PSE_IDX_IRQ_CLEAR, 32'h00000007);
		rchk(PSE_IDX_IRQ_STATUS, 32'h00000000);
		check(irq, 1'b0);
		// Core word fetched by the external reader
		bus(1'b1, PSE_IDX_PSP_DATA, 32'h0000005A);
		rchk(PSE_IDX_DIR, 32'h00000057);
		host.ext_read(b);
		check(b, 8'h5A);
		rchk(PSE_IDX_DIR, 32'h00000017);
		rchk(PSE_IDX_IRQ_STATUS, 32'h00000002);
		check(irq, 1'b1);
		// Strobes ignored outside slave mode; unmapped place reads zero
		bus(1'b1, PSE_IDX_DIR, 32'h00000007);
		host.ext_write(8'h11);
		rchk(PSE_IDX_DIR, 32'h00000007);
		rchk(10'h3FF, 32'h00000000);
		check(hresp, 1'b0);
		tally_and_finish;
	end
endmodule
